// ### hw/phy_aux_control_upper.sv
// auxiliary control bank: crossover, mac interface, in-band status, test clocks
`timescale 1ns/100ps
`default_nettype none
module phy_aux_control_upper #(
   parameter int unsigned ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [phy_aux_pkg::DATA_W-1:0] pwdata,
   output logic [phy_aux_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire phy_aux_pkg::strap_s strap_pins,
   input wire logic autoneg_enable,
   input wire logic pair_swap_detect,
   input wire phy_aux_pkg::link_info_s link_info,
   input wire logic rx_frame_active,
   input wire logic [2:0] test_mode,
   output logic crossover_active,
   output phy_aux_pkg::if_mode_e if_mode,
   output logic noncompliant_accept,
   output logic [3:0] rxd_status,
   output logic rxd_status_oe,
   output logic test_transmit_clock,
   output logic sync_clock,
   output logic test_trigger
);
   import phy_aux_pkg::*;

   if (ADDR_W < 7) begin : g_addr_check
      $error("address width too small for register map");
   end

   strap_s strap_s1_r;
   strap_s strap_s2_r;
   init_e init_r;
   logic [1:0] settle_cnt_r;
   aux_control_s ctrl_r;
   logic run;
   logic ready_r;
   logic is_aux;
   logic is_link;
   logic wr_fire;
   logic [REG_W-1:0] rd_val;
   logic [REG_W-1:0] link_word;
   logic crossover_nxt;
   logic test_on;
   logic sync_run;
   logic [2:0] sync_half;
   logic [2:0] sync_cnt_r;
   logic sync_r;
   logic tclk_r;
   logic trig_r;
   logic xover_r;
   if_mode_e if_mode_r;
   logic noncomp_r;
   logic [3:0] rxd_r;
   logic rxd_oe_r;
   logic [DATA_W-1:0] prdata_r;
   logic pslverr_r;

   // strap pins come from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_s1_r <= '0;
         strap_s2_r <= '0;
      end else begin
         strap_s1_r <= strap_pins;
         strap_s2_r <= strap_s1_r;
      end
   end

   // hold the bus off until the synchronised straps are loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_r <= ST_RESET;
         settle_cnt_r <= 2'h0;
         ready_r <= 1'b0;
      end else begin
         // ready a cycle after run so prdata_r already holds loaded fields
         ready_r <= (init_r == ST_RUN);
         case (init_r)
            ST_RESET: begin
               init_r <= ST_SETTLE;
               settle_cnt_r <= 2'h0;
            end
            ST_SETTLE: begin
               settle_cnt_r <= settle_cnt_r + 2'h1;
               if (settle_cnt_r == SETTLE_CYCLES) begin
                  init_r <= ST_RUN;
               end
            end
            default: begin
               init_r <= ST_RUN;
            end
         endcase
      end
   end

   assign run = (init_r == ST_RUN);

   // address decode
   always_comb begin
      is_aux = 1'b0;
      is_link = 1'b0;
      if (paddr == ADDR_W'(ADDR_AUX_CONTROL)) begin
         is_aux = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_LINK_STATUS)) begin
         is_link = 1'b1;
      end
   end

   assign wr_fire = psel && penable && pready && pwrite && is_aux;

   // writable fields take effect at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= AUX_CLEAR;
      end else if (init_r == ST_SETTLE && settle_cnt_r == SETTLE_CYCLES) begin
         ctrl_r <= AUX_CLEAR;
         ctrl_r.auto_xover <= strap_s2_r.auto_xover;
         ctrl_r.manual_xover <= strap_s2_r.manual_xover;
         ctrl_r.if_sel <= strap_s2_r.if_sel;
         ctrl_r.noncompliant <= strap_s2_r.noncompliant;
      end else if (wr_fire) begin
         // reserved and lower bits not stored
         ctrl_r <= AUX_CLEAR;
         ctrl_r.auto_xover <= pwdata[15];
         ctrl_r.manual_xover <= pwdata[14];
         ctrl_r.if_sel <= pwdata[13:12];
         ctrl_r.noncompliant <= pwdata[9];
         ctrl_r.inband_en <= pwdata[8];
         ctrl_r.tclk_en <= pwdata[7];
         ctrl_r.sync_en <= pwdata[6];
      end
   end

   always_comb begin
      link_word = '0;
      link_word[POS_XOVER_STAT] = xover_r;
      link_word[POS_SPEED_LO +: 2] = link_info.speed;
      link_word[POS_LINK] = link_info.link_up;
      link_word[POS_DUPLEX] = link_info.full_duplex;
   end

   always_comb begin
      rd_val = '0;
      if (is_aux) begin
         rd_val = ctrl_r;
      end else if (is_link) begin
         rd_val = link_word;
      end
   end

   // zero wait states once ready; unmapped addresses answer with an error
   assign pready = ready_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= psel ? DATA_W'(rd_val) : '0;
         pslverr_r <= psel && !(is_aux || is_link);
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r && psel && penable;

   always_comb begin
      if (ctrl_r.auto_xover && autoneg_enable) begin
         crossover_nxt = pair_swap_detect;
      end else begin
         crossover_nxt = ctrl_r.manual_xover;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xover_r <= 1'b0;
      end else begin
         xover_r <= run && crossover_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         if_mode_r <= IF_GMII;
         noncomp_r <= 1'b0;
      end else begin
         noncomp_r <= ctrl_r.noncompliant;
         case (ctrl_r.if_sel)
            2'h3: begin
               if_mode_r <= IF_RGMII_V1;
            end
            2'h2: begin
               if_mode_r <= IF_RGMII_V2;
            end
            default: begin
               if_mode_r <= IF_GMII;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_r <= 4'h0;
         rxd_oe_r <= 1'b0;
      end else if (run && ctrl_r.inband_en && ctrl_r.if_sel[1] && !rx_frame_active) begin
         rxd_r <= link_info;
         rxd_oe_r <= 1'b1;
      end else begin
         rxd_r <= 4'h0;
         rxd_oe_r <= 1'b0;
      end
   end

   // test clock only when enabled in a test
   assign test_on = run && (test_mode != TM_OFF);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tclk_r <= 1'b0;
      end else begin
         tclk_r <= test_on && ctrl_r.tclk_en && !tclk_r;
      end
   end

   // sync and trigger need bit 6
   // only test modes 1 and 4
   assign sync_run = test_on && ctrl_r.sync_en &&
                     ((test_mode == TM_ONE) || (test_mode == TM_FOUR));
   assign sync_half = (test_mode == TM_FOUR) ? SYNC_HALF_TM4 : SYNC_HALF_TM1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_cnt_r <= 3'h0;
         sync_r <= 1'b0;
         trig_r <= 1'b0;
      end else if (!sync_run) begin
         sync_cnt_r <= 3'h0;
         sync_r <= 1'b0;
         trig_r <= 1'b0;
      end else if (sync_cnt_r == sync_half - 3'h1) begin
         sync_cnt_r <= 3'h0;
         sync_r <= !sync_r;
         trig_r <= !sync_r;
      end else begin
         sync_cnt_r <= sync_cnt_r + 3'h1;
         trig_r <= 1'b0;
      end
   end

   assign crossover_active = xover_r;
   assign if_mode = if_mode_r;
   assign noncompliant_accept = noncomp_r;
   assign rxd_status = rxd_r;
   assign rxd_status_oe = rxd_oe_r;
   assign test_transmit_clock = tclk_r;
   assign sync_clock = sync_r;
   assign test_trigger = trig_r;

   a_auto_xover_follow: assert property (@(posedge pclk) disable iff (!presetn)
      run && ctrl_r.auto_xover && autoneg_enable |=> xover_r == $past(pair_swap_detect))
      else $error("auto crossover does not follow detector");

   a_an_off_manual: assert property (@(posedge pclk) disable iff (!presetn)
      run && !autoneg_enable |=> xover_r == $past(ctrl_r.manual_xover))
      else $error("manual value not applied with autoneg off");

   a_manual_xover_value: assert property (@(posedge pclk) disable iff (!presetn)
      run && !ctrl_r.auto_xover ##1 run |-> xover_r == $past(ctrl_r.manual_xover))
      else $error("manual crossover value not applied");

   a_if_mode_map: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 if_mode_r == ($past(ctrl_r.if_sel) == 2'h3 ? IF_RGMII_V1 :
                        $past(ctrl_r.if_sel) == 2'h2 ? IF_RGMII_V2 : IF_GMII))
      else $error("interface mode mismatch");

   a_noncomp_follow: assert property (@(posedge pclk) disable iff (!presetn)
      run |=> noncomp_r == $past(ctrl_r.noncompliant))
      else $error("non-compliant output lags enable");

   a_inband_drive: assert property (@(posedge pclk) disable iff (!presetn)
      run && ctrl_r.inband_en && ctrl_r.if_sel[1] && !rx_frame_active
      |=> rxd_status_oe && rxd_status == $past(link_info))
      else $error("in-band status not driven in gap");

   a_inband_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.if_sel[1] || rx_frame_active |=> !rxd_status_oe)
      else $error("in-band status without reduced mode");

   a_tclk_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.tclk_en [*2] |-> !test_transmit_clock)
      else $error("test clock driven while disabled");

   a_sync_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.sync_en |=> !sync_clock && !test_trigger)
      else $error("sync or trigger while disabled");

   a_sync_mode_only: assert property (@(posedge pclk) disable iff (!presetn)
      test_mode != TM_ONE && test_mode != TM_FOUR |=> !sync_clock && !test_trigger)
      else $error("sync outside modes 1 and 4");

   a_sync_div_four: assert property (@(posedge pclk) disable iff (!presetn)
      sync_run && test_mode == TM_ONE && $rose(sync_r)
      ##1 (sync_run && test_mode == TM_ONE) [*4] |-> !sync_r && $past(sync_r))
      else $error("sync half period not four cycles in mode 1");

   a_sync_div_six: assert property (@(posedge pclk) disable iff (!presetn)
      sync_run && test_mode == TM_FOUR && $rose(sync_r)
      ##1 (sync_run && test_mode == TM_FOUR) [*6] |-> !sync_r && $past(sync_r))
      else $error("sync half period not six cycles in mode 4");

   a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && is_link |=> prdata[POS_XOVER_STAT] == $past(xover_r))
      else $error("status bit does not show crossover");

   a_strap_load: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(run) |-> ctrl_r.auto_xover == $past(strap_s2_r.auto_xover)
      && ctrl_r.if_sel == $past(strap_s2_r.if_sel)
      && !ctrl_r.inband_en && !ctrl_r.tclk_en && !ctrl_r.sync_en)
      else $error("strap defaults not loaded");

   a_write_readback: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire |=> ctrl_r[15:12] == $past(pwdata[15:12])
      && ctrl_r[9:6] == $past(pwdata[9:6]) && ctrl_r.rsvd == 2'h0)
      else $error("written fields not stored");

endmodule : phy_aux_control_upper
`default_nettype wire

// ### hw/phy_aux_pkg.sv
// package: register map, field layout and timing counts of the auxiliary control bank
package phy_aux_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [4:0] IDX_LINK_STATUS = 5'h11;
   localparam logic [4:0] IDX_AUX_CONTROL = 5'h12;
   localparam logic [6:0] ADDR_LINK_STATUS = {IDX_LINK_STATUS, 2'h0};
   localparam logic [6:0] ADDR_AUX_CONTROL = {IDX_AUX_CONTROL, 2'h0};
   // link status field positions
   localparam int unsigned POS_XOVER_STAT = 10;
   localparam int unsigned POS_SPEED_LO = 3;
   localparam int unsigned POS_LINK = 2;
   localparam int unsigned POS_DUPLEX = 1;
   // auxiliary control word, bit 15 down to bit 0
   typedef struct packed {
      logic auto_xover;
      logic manual_xover;
      logic [1:0] if_sel;
      logic [1:0] rsvd;
      logic noncompliant;
      logic inband_en;
      logic tclk_en;
      logic sync_en;
      logic [5:0] low;
   } aux_control_s;
   localparam aux_control_s AUX_CLEAR = 16'h0000;
   typedef struct packed {
      logic auto_xover;
      logic manual_xover;
      logic [1:0] if_sel;
      logic noncompliant;
   } strap_s;
   // in-band nibble order: duplex, speed, link
   typedef struct packed {
      logic full_duplex;
      logic [1:0] speed;
      logic link_up;
   } link_info_s;
   typedef enum logic [1:0] {
      IF_GMII = 2'h0,
      IF_RGMII_V2 = 2'h2,
      IF_RGMII_V1 = 2'h3
   } if_mode_e;
   typedef enum logic [1:0] {
      ST_RESET = 2'h0,
      ST_SETTLE = 2'h1,
      ST_RUN = 2'h3
   } init_e;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;
   localparam logic [2:0] TM_OFF = 3'h0;
   localparam logic [2:0] TM_ONE = 3'h1;
   localparam logic [2:0] TM_FOUR = 3'h4;
   // test clock is pclk / 2; sync is test clock / 4 or / 6
   localparam int unsigned TCLK_RATIO = 2;
   localparam int unsigned SYNC_DIV_TM1 = 4;
   localparam int unsigned SYNC_DIV_TM4 = 6;
   localparam logic [2:0] SYNC_HALF_TM1 = 3'(SYNC_DIV_TM1 * TCLK_RATIO / 2);
   localparam logic [2:0] SYNC_HALF_TM4 = 3'(SYNC_DIV_TM4 * TCLK_RATIO / 2);
endpackage : phy_aux_pkg

// ### verification/tb_top.sv
// self-checking bench for the auxiliary control bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import phy_aux_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   strap_s strap_pins = 5'h00;
   logic autoneg_enable = 1'b1;
   logic pair_swap_detect = 1'b0;
   link_info_s link_info = 4'ha;
   logic rx_frame_active = 1'b0;
   logic [2:0] test_mode = 3'h0;
   logic crossover_active;
   if_mode_e if_mode;
   logic noncompliant_accept;
   logic [3:0] rxd_status;
   logic rxd_status_oe;
   logic test_transmit_clock;
   logic sync_clock;
   logic test_trigger;
   int err_count = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;
   localparam logic [7:0] A_AUX = 8'(ADDR_AUX_CONTROL);
   localparam logic [7:0] A_LNK = 8'(ADDR_LINK_STATUS);
   localparam logic [7:0] A_BAD = 8'h4c;

   phy_aux_control_upper #(.ADDR_W(8)) u_phy_aux_control_upper (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .strap_pins(strap_pins),
      .autoneg_enable(autoneg_enable),
      .pair_swap_detect(pair_swap_detect),
      .link_info(link_info),
      .rx_frame_active(rx_frame_active),
      .test_mode(test_mode),
      .crossover_active(crossover_active),
      .if_mode(if_mode),
      .noncompliant_accept(noncompliant_accept),
      .rxd_status(rxd_status),
      .rxd_status_oe(rxd_status_oe),
      .test_transmit_clock(test_transmit_clock),
      .sync_clock(sync_clock),
      .test_trigger(test_trigger)
   );

   always #25 pclk = ~pclk;

   task automatic conclude();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   // one apb transfer; waits on pready, result in rd and er
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(negedge pclk);
      while (pready !== 1'b1 && n < 100) begin
         n++;
         @(negedge pclk);
      end
      if (n >= 100) err_count++;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic do_reset(input strap_s s);
      @(posedge pclk);
      presetn <= 1'b0;
      strap_pins <= s;
      repeat (4) @(posedge pclk);
      chk("pready in reset", 32'(pready), 32'h0);
      chk("if_mode in reset", 32'(if_mode), 32'h0);
      presetn <= 1'b1;
   endtask : do_reset

   task automatic xcase(input logic [31:0] aux, input logic an, input logic sw, input logic ex);
      apb(1'b1, A_AUX, aux);
      @(posedge pclk);
      autoneg_enable <= an;
      pair_swap_detect <= sw;
      settle(2);
      chk("crossover", 32'(crossover_active), 32'(ex));
      apb(1'b0, A_LNK, 32'h0);
      chk("crossover status", 32'(rd[POS_XOVER_STAT]), 32'(ex));
   endtask : xcase

   // counts test clock edges, sync rises and trigger cycles over 48 cycles
   task automatic tcase(input logic [31:0] aux, input logic [2:0] m, input int et, input int es);
      int t;
      int s;
      int g;
      logic pt;
      logic ps;
      t = 0;
      s = 0;
      g = 0;
      apb(1'b1, A_AUX, aux);
      @(posedge pclk);
      test_mode <= m;
      settle(10);
      pt = test_transmit_clock;
      ps = sync_clock;
      repeat (48) begin
         @(negedge pclk);
         t += (test_transmit_clock !== pt);
         s += (sync_clock === 1'b1 && ps === 1'b0);
         g += (test_trigger === 1'b1);
         pt = test_transmit_clock;
         ps = sync_clock;
      end
      chk("test clock toggles", t, et);
      chk("sync rises", s, es);
      chk("trigger pulses", g, es);
   endtask : tcase

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      conclude();
   end

   initial begin
      do_reset(5'h17);
      apb(1'b0, A_AUX, 32'h0);
      chk("aux after strap", rd, 32'h0000_b200);
      settle(2);
      chk("if_mode strap", 32'(if_mode), 32'h3);
      chk("nc strap", 32'(noncompliant_accept), 32'h1);
      $display("test strap_load done");
      apb(1'b1, A_AUX, 32'h0000_b3c0);
      apb(1'b0, A_AUX, 32'h0);
      chk("aux readback", rd, 32'h0000_b3c0);
      apb(1'b1, A_BAD, 32'h0000_4000);
      chk("unmapped error", 32'(er), 32'h1);
      apb(1'b0, A_BAD, 32'h0);
      chk("unmapped data", rd, 32'h0);
      apb(1'b1, A_LNK, 32'h0000_ffff);
      apb(1'b0, A_AUX, 32'h0);
      chk("aux after dropped writes", rd, 32'h0000_b3c0);
      do_reset(5'h08);
      apb(1'b0, A_AUX, 32'h0);
      chk("aux after second reset", rd, 32'h0000_4000);
      $display("test access done");
      xcase(32'h0000_8000, 1'b1, 1'b1, 1'b1);
      xcase(32'h0000_8000, 1'b1, 1'b0, 1'b0);
      xcase(32'h0000_c000, 1'b1, 1'b0, 1'b0);
      xcase(32'h0000_8000, 1'b0, 1'b1, 1'b0);
      xcase(32'h0000_c000, 1'b0, 1'b0, 1'b1);
      xcase(32'h0000_4000, 1'b1, 1'b0, 1'b1);
      xcase(32'h0000_0000, 1'b1, 1'b1, 1'b0);
      $display("test crossover done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, A_AUX, (32'(i) << 12) | (32'(i & 1) << 9) | 32'h0000_0100);
         settle(2);
         chk("if_mode", 32'(if_mode), i == 3 ? 32'h3 : (i == 2 ? 32'h2 : 32'h0));
         chk("nc accept", 32'(noncompliant_accept), 32'(i & 1));
         chk("inband enable", 32'(rxd_status_oe), 32'(i >> 1));
         chk("inband nibble", 32'(rxd_status), i > 1 ? 32'ha : 32'h0);
      end
      @(posedge pclk);
      rx_frame_active <= 1'b1;
      settle(2);
      chk("inband in frame", 32'(rxd_status_oe), 32'h0);
      @(posedge pclk);
      rx_frame_active <= 1'b0;
      apb(1'b1, A_AUX, 32'h0000_3000);
      settle(2);
      chk("inband disabled", 32'(rxd_status_oe), 32'h0);
      $display("test interface done");
      tcase(32'h0000_0000, 3'h1, 0, 0);
      tcase(32'h0000_0080, 3'h0, 0, 0);
      tcase(32'h0000_0080, 3'h1, 48, 0);
      tcase(32'h0000_00c0, 3'h1, 48, 6);
      tcase(32'h0000_00c0, 3'h4, 48, 4);
      tcase(32'h0000_00c0, 3'h2, 48, 0);
      tcase(32'h0000_00c0, 3'h3, 48, 0);
      $display("test test_clocks done");
      conclude();
   end
endmodule : tb_top
`default_nettype wire
